//--- src/pwr_map.svh
// constants for the power state and reset controller
// assumes a 250 MHz system clock and a 2 MHz slow clock strobe
`ifndef PWR_MAP_SVH
`define PWR_MAP_SVH
`define PWR_CLK_PERIOD_NS   4
`define PWR_SLOW_DIV        64
`define PWR_STRETCH_TICKS   256
`define PWR_DIV_W           6
`define PWR_CNT_W           8
`define PWR_CMD_W           2
`define PWR_CMD_NONE        2'h0
`define PWR_CMD_TX          2'h1
`define PWR_CMD_RX          2'h2
`define PWR_CMD_CPU         2'h3
`endif

//--- src/pwr_pkg.sv
// types for the power state and reset controller
// no surroundings assumed
package pwr_pkg;
    typedef enum logic [2:0] {
        PWR_CORE_OFF,
        PWR_CPU_ONLY,
        PWR_RADIO_TX,
        PWR_RADIO_RX,
        PWR_DEEP_SLEEP
    } pwr_state_t;
endpackage

//--- src/pwr_tick_if.sv
// slow tick carried from the divider to the controller
// one clock domain
`timescale 1ns/1ps
interface pwr_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

//--- src/pwr_div.sv
// divides the 2 MHz strobe by 64 into one tick
// assumes slow_en is a one-cycle strobe at 2 MHz in the clk domain
`timescale 1ns/1ps
`include "pwr_map.svh"
module pwr_div (
    input  wire logic clk,      // system clock
    input  wire logic rst,      // async reset, high
    input  wire logic slow_en,  // 2 MHz strobe
    pwr_tick_if.src   tk        // divided tick
);
    typedef struct packed {
        logic [`PWR_DIV_W-1:0] cnt;
        logic                  tick;
    } pwr_div_st_t;
    pwr_div_st_t st_reg;
    pwr_div_st_t st_next;
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (slow_en) begin
            st_next.cnt = st_reg.cnt + `PWR_DIV_W'(1);
            if (st_reg.cnt == `PWR_DIV_W'(`PWR_SLOW_DIV - 1)) begin
                st_next.tick = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign tk.tick = st_reg.tick;
endmodule

//--- src/pwr_ctrl.sv
// power state sequencer and stretched reset generator
// detector levels and commands are synchronous to clk; slow_en is a 2 MHz strobe
`timescale 1ns/1ps
`include "pwr_map.svh"
// Notes on behaviour
// - five states: radio tx, radio rx, cpu only, deep sleep, core off
// - radio may be active only while the processor is powered
// - enable low selects core off; high moves to cpu only; low returns
// - past cpu only, only software commands move the state, save the forced return to core off on pin, supply or reset
// - supply-low indication high while battery input under threshold
// - bandgap drop indication high while reference below programmed threshold
// - reset held for 256 ticks of the 2 MHz clock over 64
module pwr_ctrl (
    input  wire logic                  clk,          // system clock
    input  wire logic                  rst,          // async reset, high
    input  wire logic                  slow_en,      // 2 MHz strobe
    input  wire logic                  pu_enable,    // power-unit enable pin
    input  wire logic                  io_supply,    // io supply present
    input  wire logic                  battery_low,  // battery_input under threshold
    input  wire logic                  ref_low,      // reference_voltage under threshold
    input  wire logic                  sw_cmd_valid, // software command strobe
    input  wire logic [`PWR_CMD_W-1:0] sw_cmd,       // target state command
    input  wire logic                  sw_sleep,     // software request deep sleep
    input  wire logic                  sw_wake,      // software wake from deep sleep
    output logic                       supply_low,   // supply-low reset indication
    output logic                       bandgap_drop_detect, // reference drop indication
    output logic                       chip_reset,   // stretched chip reset
    output logic                       cpu_on,       // processor powered
    output logic                       radio_on,     // radio powered
    output logic [2:0]                 state         // current device state
);
    typedef struct packed {
        pwr_pkg::pwr_state_t   st;
        logic [`PWR_CNT_W-1:0] cnt;
        logic                  rst_o;
        logic                  sl;
        logic                  bd;
        logic                  cpu;
        logic                  radio;
    } pwr_ctrl_st_t;
    pwr_ctrl_st_t s_reg;
    pwr_ctrl_st_t s_next;
    pwr_tick_if   tk ();

    pwr_div u_div (
        .clk     (clk),
        .rst     (rst),
        .slow_en (slow_en),
        .tk      (tk)
    );

    function automatic logic radio_state(input pwr_pkg::pwr_state_t x);
        return (x == pwr_pkg::PWR_RADIO_TX) || (x == pwr_pkg::PWR_RADIO_RX);
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.sl = battery_low;
        s_next.bd = ref_low;
        // stretch: any detector restarts, quiet full count releases
        if (battery_low || ref_low) begin
            s_next.cnt   = '0;
            s_next.rst_o = 1'b1;
        end else if (s_reg.rst_o && tk.tick) begin
            if (s_reg.cnt == `PWR_CNT_W'(`PWR_STRETCH_TICKS - 1)) begin
                s_next.rst_o = 1'b0;
            end else begin
                s_next.cnt = s_reg.cnt + `PWR_CNT_W'(1);
            end
        end
        // pin only governs core off; reset or lost pin forces core off
        if (!pu_enable || !io_supply || s_next.rst_o) begin
            s_next.st = pwr_pkg::PWR_CORE_OFF;
        end else begin
            case (s_reg.st)
                pwr_pkg::PWR_CORE_OFF: begin
                    s_next.st = pwr_pkg::PWR_CPU_ONLY;
                end
                pwr_pkg::PWR_CPU_ONLY, pwr_pkg::PWR_RADIO_TX,
                pwr_pkg::PWR_RADIO_RX: begin
                    // software only from here on
                    if (sw_sleep) begin
                        s_next.st = pwr_pkg::PWR_DEEP_SLEEP;
                    end else if (sw_cmd_valid) begin
                        case (sw_cmd)
                            `PWR_CMD_TX:  s_next.st = pwr_pkg::PWR_RADIO_TX;
                            `PWR_CMD_RX:  s_next.st = pwr_pkg::PWR_RADIO_RX;
                            `PWR_CMD_CPU: s_next.st = pwr_pkg::PWR_CPU_ONLY;
                            default:      s_next.st = s_reg.st;
                        endcase
                    end
                end
                pwr_pkg::PWR_DEEP_SLEEP: begin
                    if (sw_wake) begin
                        s_next.st = pwr_pkg::PWR_CPU_ONLY;
                    end
                end
                default: s_next.st = pwr_pkg::PWR_CORE_OFF;
            endcase
        end
        s_next.cpu   = (s_next.st == pwr_pkg::PWR_CPU_ONLY) || radio_state(s_next.st);
        // radio gated by processor power in the same cycle
        s_next.radio = radio_state(s_next.st) && s_next.cpu;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg.st    <= pwr_pkg::PWR_CORE_OFF;
            s_reg.cnt   <= '0;
            s_reg.rst_o <= 1'b1;
            s_reg.sl    <= 1'b0;
            s_reg.bd    <= 1'b0;
            s_reg.cpu   <= 1'b0;
            s_reg.radio <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign supply_low          = s_reg.sl;
    assign bandgap_drop_detect = s_reg.bd;
    assign chip_reset          = s_reg.rst_o;
    assign cpu_on              = s_reg.cpu;
    assign radio_on            = s_reg.radio;
    assign state               = s_reg.st;
endmodule

//--- tb/pwr_ctrl_assertions.sv
// port checks for the power controller
// bound into pwr_ctrl, one clock domain
`timescale 1ns/1ps
module pwr_ctrl_assertions (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       pu_enable,
    input wire logic       battery_low,
    input wire logic       ref_low,
    input wire logic       sw_cmd_valid,
    input wire logic       sw_sleep,
    input wire logic       sw_wake,
    input wire logic       supply_low,
    input wire logic       bandgap_drop_detect,
    input wire logic       chip_reset,
    input wire logic       cpu_on,
    input wire logic       radio_on,
    input wire logic [2:0] state
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence det_hi; battery_low || ref_low; endsequence
    sequence held_rst; chip_reset[*8]; endsequence
    radio_needs_cpu_a: assert property (radio_on |-> cpu_on) else $error("radio alone");
    state_legal_a: assert property (state <= 3'h4) else $error("bad state");
    supply_follow_a: assert property (!$past(rst) |-> supply_low == $past(battery_low))
        else $error("supply_low wrong");
    ref_follow_a: assert property (!$past(rst) |-> bandgap_drop_detect == $past(ref_low))
        else $error("drop flag wrong");
    stretch_hold_a: assert property (det_hi |=> held_rst) else $error("reset short");
    quiet_release_a: assert property ($fell(chip_reset) |->
        !$past(supply_low) && !$past(bandgap_drop_detect)) else $error("release early");
    pin_off_a: assert property (!pu_enable |=> state == 3'h0 && !cpu_on)
        else $error("pin low not off");
    sw_only_a: assert property (!$past(rst) && $past(state) != 3'h0 && state != 3'h0
        && state != $past(state) |-> $past(sw_cmd_valid || sw_sleep || sw_wake))
        else $error("move without software");
endmodule
bind pwr_ctrl pwr_ctrl_assertions i_chk (.clk(clk), .rst(rst), .pu_enable(pu_enable),
    .battery_low(battery_low), .ref_low(ref_low), .sw_cmd_valid(sw_cmd_valid),
    .sw_sleep(sw_sleep), .sw_wake(sw_wake), .supply_low(supply_low),
    .bandgap_drop_detect(bandgap_drop_detect), .chip_reset(chip_reset), .cpu_on(cpu_on),
    .radio_on(radio_on), .state(state));

//--- tb/pwr_host_model.sv
// outside party driving the enable pin and the io supply
// updates on the rising edge by non-blocking assignment
`timescale 1ns/1ps
module pwr_host_model (
    input  wire logic clk,       // system clock
    input  wire logic want_on,   // request processor power
    output logic      pu_enable, // power-unit enable pin
    output logic      io_supply  // io supply present
);
    initial pu_enable = 1'b0;
    initial io_supply = 1'b1;
    // supply kept up while pin is low, so core off is selected
    always @(posedge clk) begin
        io_supply <= 1'b1;
        pu_enable <= want_on;
    end
endmodule

//--- tb/power_state_and_reset_control_tb_top.sv
// self-checking bench for the power controller
// slow_en pulses every cycle, so the stretch lasts 256*64 cycles
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module power_state_and_reset_control_tb_top;
    logic clk = 1'b0, rst = 1'b1, want_on = 1'b0, battery_low = 1'b0, ref_low = 1'b0;
    logic sw_cmd_valid = 1'b0, sw_sleep = 1'b0, sw_wake = 1'b0;
    logic [1:0] sw_cmd = 2'h0;
    logic pu_enable, io_supply, supply_low, bandgap_drop_detect, chip_reset, cpu_on, radio_on;
    logic [2:0] state;
    int n_fail = 0, comparisons = 0, cyc = 0, m = 0, n;
    always #2 clk = ~clk;
    pwr_host_model i_host (.clk(clk), .want_on(want_on), .pu_enable(pu_enable),
        .io_supply(io_supply));
    pwr_ctrl i_dut (.clk(clk), .rst(rst), .slow_en(1'b1), .pu_enable(pu_enable),
        .io_supply(io_supply), .battery_low(battery_low), .ref_low(ref_low),
        .sw_cmd_valid(sw_cmd_valid), .sw_cmd(sw_cmd), .sw_sleep(sw_sleep), .sw_wake(sw_wake),
        .supply_low(supply_low), .bandgap_drop_detect(bandgap_drop_detect),
        .chip_reset(chip_reset), .cpu_on(cpu_on), .radio_on(radio_on), .state(state));
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check_state;
        `CHK(state, 3'(m))
        `CHK(radio_on, 1'(m == 2 || m == 3))
        `CHK(cpu_on, 1'(m >= 1 && m <= 3))
    endtask
    // divider runs free after the first release, so the first tick lands 1..64 edges late
    task automatic wait_release;
        n = 0;
        while (chip_reset !== 1'b0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        `CHK(1'(n >= 255 * 64 + 1 && n <= 256 * 64 + 1), 1'b1)
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        void'($urandom(32'hf40e));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        want_on = 1'b1;
        wait_release;
        repeat (2) @(negedge clk);
        m = 1;
        check_state;
        repeat (40) begin
            sw_cmd_valid = 1'($urandom);
            sw_cmd = 2'($urandom);
            sw_sleep = ($urandom % 8) == 0;
            sw_wake = !sw_sleep && ($urandom % 4) == 0;
            if (sw_sleep && m != 4) m = 4;
            else if (m == 4) m = sw_wake ? 1 : 4;
            else if (sw_cmd_valid && sw_cmd != 2'h0) m = (sw_cmd == 2'h3) ? 1 : sw_cmd + 1;
            @(negedge clk);
            check_state;
        end
        {sw_cmd_valid, sw_sleep, sw_wake, want_on} = 4'h0;
        repeat (2) @(negedge clk);
        m = 0;
        check_state;
        {sw_cmd_valid, sw_cmd} = 3'h5;
        @(negedge clk);
        sw_cmd_valid = 1'b0;
        check_state;
        battery_low = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(supply_low, 1'b1)
        `CHK(chip_reset, 1'b1)
        {battery_low, ref_low} = 2'h1;
        repeat (2) @(negedge clk);
        `CHK(supply_low, 1'b0)
        `CHK(bandgap_drop_detect, 1'b1)
        ref_low = 1'b0;
        wait_release;
        tally_and_finish;
    end
endmodule
